// [rtl/ivr_pkg.sv]
// interrupt request vectoring: shared constants, types and cause layout
// assumes one synchronous system clock and the core's exception logic outside
// Overview of operation
// - vector base offset resets to zero
// - stack pointer at 0x00, reset at 0x04
// - five reset causes enter the reset vector
// - watchdog overflow gives reset or nmi, selectable
// - bus, undefined, unaligned errors raise hard fault
// - reset, nmi, hard fault fixed at -3,-2,-1
// - configurable priority 0..192, lower wins
// - svc, pendable_service_exception, system_tick_exception priorities configurable
// - request lines map to numbers 16..45
// - line 0 carries dma completion or error
// - lines 19 and 27 are shared
// - flag and enable per cause
// - flag sets on event, cleared per peripheral
// - request only while flag and enable
// - enabling a set flag requests immediately
// - watchdog nmi outranks all but reset, never masked
package ivr_pkg;
   localparam int          NUM_LINES      = 30;
   localparam int          MAX_CAUSES     = 16;
   localparam int          NUM_EXC        = 48;
   localparam logic [5:0]  EXC_RESET      = 6'h01;
   localparam logic [5:0]  EXC_NMI        = 6'h02;
   localparam logic [5:0]  EXC_HARD_FAULT = 6'h03;
   localparam logic [5:0]  EXC_SVC        = 6'h0b;
   localparam logic [5:0]  EXC_PENDABLE_SERVICE_EXCEPTION     = 6'h0e;
   localparam logic [5:0]  EXC_SYSTEM_TICK_EXCEPTION    = 6'h0f;
   localparam logic [5:0]  EXC_IRQ_BASE   = 6'h10;
   localparam logic [5:0]  EXC_IRQ_LAST   = 6'h2d;
   localparam logic [31:0] VBO_RESET      = 32'h0000_0000;
   localparam logic [31:0] OFS_SP         = 32'h0000_0000;
   localparam logic [1:0]  SLOT_SHIFT     = 2'h2;
   localparam logic [7:0]  PRIO_MAX       = 8'hc0;
   localparam logic [2:0]  KEY_RESET      = 3'h0;
   localparam logic [2:0]  KEY_NMI        = 3'h1;
   localparam logic [2:0]  KEY_HARD_FAULT = 3'h2;
   localparam logic [2:0]  KEY_CFG_BASE   = 3'h3;
   localparam logic [2:0]  KEY_IDLE       = 3'h7;
   localparam int          LINE_SHARED_A  = 19;
   localparam int          LINE_SHARED_B  = 27;
   localparam int          SHARED_A_SPLIT = 7;
   localparam int          SHARED_B_SPLIT = 4;
   // implemented causes per request line, index is the line number
   localparam logic [4:0] LINE_CAUSES [NUM_LINES] = '{
      5'h02, 5'h01, 5'h10, 5'h10, 5'h10, 5'h06, 5'h0d, 5'h03, 5'h02, 5'h07,
      5'h01, 5'h04, 5'h08, 5'h04, 5'h04, 5'h07, 5'h01, 5'h04, 5'h08, 5'h08,
      5'h01, 5'h04, 5'h01, 5'h01, 5'h01, 5'h05, 5'h02, 5'h05, 5'h08, 5'h02};

   typedef logic [MAX_CAUSES-1:0] ivr_cause_t;
   typedef logic [2:0]            ivr_key_t;

   typedef enum logic [1:0] {IVR_IDLE, IVR_TAKEN} ivr_state_e;

   typedef struct packed {
      logic pin_low;
      logic power_on;
      logic key;
      logic wdt_overflow;
      logic supply_detect;
   } ivr_rst_src_s;

   typedef struct packed {
      logic bus_error;
      logic undef_instr;
      logic unaligned;
   } ivr_fault_s;

   typedef struct packed {
      logic [5:0]  num;
      logic [31:0] addr;
   } ivr_vec_s;

   function automatic ivr_cause_t cause_mask(input logic [4:0] cnt);
      ivr_cause_t m;
      m = '0;
      for (int i = 0; i < MAX_CAUSES; i++)
      begin
         if (i < int'(cnt))
            m[i] = 1'b1;
      end
      return m;
   endfunction
endpackage

// [rtl/ivr_line_flags.sv]
// interrupt request vectoring: flags and level of one request line
// assumes set, clear and enable come from the owning peripherals synchronously
`timescale 1ns/100ps
module ivr_line_flags
   import ivr_pkg::*;
#(
   parameter logic [4:0] CAUSES = 5'h01
)
(
   input  wire logic       i_clk,    // system clock
   input  wire logic       i_rstn,   // async reset, active low
   input  wire ivr_cause_t i_set,    // cause event pulses
   input  wire ivr_cause_t i_clr,    // per-cause clear pulses
   input  wire ivr_cause_t i_en,     // per-cause enable bits
   output      ivr_cause_t o_flag,   // sticky cause flags
   output      logic       o_level   // combined request level
);
   ivr_cause_t flag_r;
   ivr_cause_t flag_nxt;

   // unimplemented slots never hold a flag
   always_comb
   begin
      flag_nxt = ((flag_r & ~i_clr) | i_set) & cause_mask(CAUSES);
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         flag_r <= '0;
      else
         flag_r <= flag_nxt;
   end

   assign o_flag  = flag_r;
   assign o_level = |(flag_r & i_en);
endmodule

// [rtl/ivr_prio_pick.sv]
// interrupt request vectoring: picks the most urgent pending exception
// assumes keys are ranks, lower key wins, ties go to the lower number
`timescale 1ns/100ps
module ivr_prio_pick
   import ivr_pkg::*;
(
   input  wire ivr_key_t   i_key [NUM_EXC], // rank per exception number
   output      logic       o_vld,           // something is pending
   output      logic [5:0] o_num            // winning exception number
);
   ivr_key_t best;

   always_comb
   begin
      best  = KEY_IDLE;
      o_num = '0;
      for (int i = 0; i < NUM_EXC; i++)
      begin
         if (i_key[i] < best)
         begin
            best  = i_key[i];
            o_num = 6'(i);
         end
      end
      o_vld = (best != KEY_IDLE);
   end
endmodule

// [rtl/ivr_top.sv]
// interrupt request vectoring: cause flags, request lines, fixed exceptions,
// vector base offset and selection of the most urgent exception
// assumes every input is synchronous to i_clk; the core acknowledges the nmi
// and hard fault with one-cycle pulses and writes the vector base offset here
`timescale 1ns/100ps
module ivr_top
   import ivr_pkg::*;
(
   input  wire logic         i_clk,                     // system clock, 40 mhz
   input  wire logic         i_rstn,                    // async reset, active low
   input  wire ivr_cause_t   i_cause_set [NUM_LINES],   // cause events per line
   input  wire ivr_cause_t   i_cause_clr [NUM_LINES],   // cause clears per line
   input  wire ivr_cause_t   i_cause_en  [NUM_LINES],   // cause enables per line
   input  wire logic [7:0]   i_line_prio [NUM_LINES],   // priority per line
   input  wire ivr_rst_src_s i_rst_src,                 // reset causes, levels
   input  wire logic         i_wdt_nmi_sel,             // watchdog gives nmi
   input  wire ivr_fault_s   i_fault,                   // fault event pulses
   input  wire logic         i_svc_pend,                // supervisor call pending
   input  wire logic         i_pendable_service_exception_pend,             // pendable service pending
   input  wire logic         i_system_tick_exception_pend,            // system tick pending
   input  wire logic [7:0]   i_svc_prio,                // supervisor call priority
   input  wire logic [7:0]   i_pendable_service_exception_prio,             // pendable service priority
   input  wire logic [7:0]   i_system_tick_exception_prio,            // system tick priority
   input  wire logic         i_nmi_ack,                 // core took the nmi
   input  wire logic         i_hard_fault_ack,          // core took the hard fault
   input  wire logic         i_vbo_wr,                  // base offset write strobe
   input  wire logic [31:0]  i_vbo_wdata,               // base offset write data
   output      logic [29:0]  o_irq_line,                // request line levels
   output      logic         o_reset_req,               // reset request level
   output      logic         o_nmi,                     // nmi pending
   output      logic         o_hard_fault,              // hard fault pending
   output      logic [31:0]  o_vector_base_offset,      // current base offset
   output      logic [31:0]  o_sp_vec_addr,             // stack pointer slot
   output      logic         o_exc_vld,                 // an exception is pending
   output      ivr_vec_s     o_exc                      // winner and its slot
);
   logic [29:0]  line_level;
   ivr_cause_t   line_flag [NUM_LINES];
   ivr_cause_t   part_a;
   ivr_cause_t   part_b;
   ivr_key_t     key [NUM_EXC];
   logic         pick_vld;
   logic [5:0]   pick_num;
   logic         wdt_reset;
   logic         wdt_nmi;
   logic         fault_any;
   logic [29:0]  irq_line_r;
   logic         reset_req_r;
   logic         nmi_r;
   logic         nmi_nxt;
   logic         hard_fault_r;
   logic         hard_fault_nxt;
   logic [31:0]  vbo_r;
   logic [31:0]  sp_vec_addr_r;
   logic         exc_vld_r;
   ivr_vec_s     exc_r;
   ivr_vec_s     exc_nxt;
   ivr_state_e   state_r;
   ivr_state_e   state_nxt;

   // a priority above the top level is taken as the top level; only the
   // upper two bits count, so steps are 0, 64, 128 and 192
   function automatic ivr_key_t cfg_key(input logic pend, input logic [7:0] prio);
      logic [7:0] p;
      p = (prio > PRIO_MAX) ? PRIO_MAX : prio;
      if (!pend)
         return KEY_IDLE;
      return KEY_CFG_BASE + {1'b0, p[7:6]};
   endfunction

   function automatic logic [31:0] slot_addr(input logic [31:0] base,
                                             input logic [5:0]  num);
      return base + (32'(num) << SLOT_SHIFT);
   endfunction

   // one flag block per request line
   genvar g;
   generate
      for (g = 0; g < NUM_LINES; g++)
      begin : g_line
         ivr_line_flags #(
            .CAUSES (LINE_CAUSES[g])
         ) u_flags (
            .i_clk   (i_clk),
            .i_rstn  (i_rstn),
            .i_set   (i_cause_set[g]),
            .i_clr   (i_cause_clr[g]),
            .i_en    (i_cause_en[g]),
            .o_flag  (line_flag[g]),
            .o_level (line_level[g])
         );
      end
   endgenerate

   // shared lines: low slots belong to the serial unit, high to the timer;
   // the split is kept visible so either peripheral alone raises the line
   always_comb
   begin
      part_a = line_flag[LINE_SHARED_A] & i_cause_en[LINE_SHARED_A];
      part_b = line_flag[LINE_SHARED_B] & i_cause_en[LINE_SHARED_B];
   end

   // request lines are registered so the core sees clean levels
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         irq_line_r <= '0;
      else
      begin
         irq_line_r <= line_level;
         irq_line_r[LINE_SHARED_A] <=
            (|part_a[SHARED_A_SPLIT-1:0]) | (|part_a[MAX_CAUSES-1:SHARED_A_SPLIT]);
         irq_line_r[LINE_SHARED_B] <=
            (|part_b[SHARED_B_SPLIT-1:0]) | (|part_b[MAX_CAUSES-1:SHARED_B_SPLIT]);
      end
   end

   // watchdog overflow goes one way only, chosen by the watchdog's setting
   always_comb
   begin
      wdt_reset = i_rst_src.wdt_overflow & ~i_wdt_nmi_sel;
      wdt_nmi   = i_rst_src.wdt_overflow &  i_wdt_nmi_sel;
      fault_any = i_fault.bus_error | i_fault.undef_instr | i_fault.unaligned;
   end

   // reset causes are levels; the request follows them one cycle later
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         reset_req_r <= 1'b0;
      else
         reset_req_r <= i_rst_src.pin_low | i_rst_src.power_on | i_rst_src.key
                        | wdt_reset | i_rst_src.supply_detect;
   end

   // nmi has no mask; a new overflow in the ack cycle wins over the ack
   always_comb
   begin
      nmi_nxt = (nmi_r & ~i_nmi_ack) | wdt_nmi;
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         nmi_r <= 1'b0;
      else
         nmi_r <= nmi_nxt;
   end

   // hard fault stays pending until the core acknowledges it
   always_comb
   begin
      hard_fault_nxt = (hard_fault_r & ~i_hard_fault_ack) | fault_any;
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         hard_fault_r <= 1'b0;
      else
         hard_fault_r <= hard_fault_nxt;
   end

   // base offset; only a full reset restores zero, so reset code must
   // always be reachable at address zero
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         vbo_r <= VBO_RESET;
      else if (i_vbo_wr)
         vbo_r <= i_vbo_wdata;
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         sp_vec_addr_r <= VBO_RESET + OFS_SP;
      else
         sp_vec_addr_r <= vbo_r + OFS_SP;
   end

   // rank every exception number; reserved numbers never pend
   always_comb
   begin
      for (int i = 0; i < NUM_EXC; i++)
         key[i] = KEY_IDLE;
      key[EXC_RESET]      = reset_req_r  ? KEY_RESET      : KEY_IDLE;
      key[EXC_NMI]        = nmi_r        ? KEY_NMI        : KEY_IDLE;
      key[EXC_HARD_FAULT] = hard_fault_r ? KEY_HARD_FAULT : KEY_IDLE;
      key[EXC_SVC]        = cfg_key(i_svc_pend, i_svc_prio);
      key[EXC_PENDABLE_SERVICE_EXCEPTION]     = cfg_key(i_pendable_service_exception_pend, i_pendable_service_exception_prio);
      key[EXC_SYSTEM_TICK_EXCEPTION]    = cfg_key(i_system_tick_exception_pend, i_system_tick_exception_prio);
      for (int l = 0; l < NUM_LINES; l++)
         key[int'(EXC_IRQ_BASE) + l] = cfg_key(irq_line_r[l], i_line_prio[l]);
   end

   ivr_prio_pick u_pick (
      .i_key (key),
      .o_vld (pick_vld),
      .o_num (pick_num)
   );

   // presentation state: idle until something pends, then it follows the
   // winner every cycle so a more urgent arrival replaces the current one
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         IVR_IDLE:
         begin
            if (pick_vld)
               state_nxt = IVR_TAKEN;
         end
         IVR_TAKEN:
         begin
            if (!pick_vld)
               state_nxt = IVR_IDLE;
         end
         default:
            state_nxt = IVR_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         state_r <= IVR_IDLE;
      else
         state_r <= state_nxt;
   end

   always_comb
   begin
      exc_nxt.num  = pick_vld ? pick_num : 6'h00;
      exc_nxt.addr = pick_vld ? slot_addr(vbo_r, pick_num) : vbo_r;
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         exc_vld_r <= 1'b0;
         exc_r     <= '0;
      end
      else
      begin
         exc_vld_r <= (state_nxt == IVR_TAKEN);
         exc_r     <= exc_nxt;
      end
   end

   assign o_irq_line           = irq_line_r;
   assign o_reset_req          = reset_req_r;
   assign o_nmi                = nmi_r;
   assign o_hard_fault         = hard_fault_r;
   assign o_vector_base_offset = vbo_r;
   assign o_sp_vec_addr        = sp_vec_addr_r;
   assign o_exc_vld            = exc_vld_r;
   assign o_exc                = exc_r;
endmodule

// [tb/ivr_assertions.sv]
// interrupt request vectoring: port-level timing and ranking checks
// bound into ivr_top; sees its ports only
`timescale 1ns/100ps
module ivr_chk
   import ivr_pkg::*;
(
   input wire logic         i_clk,                // clock
   input wire logic         i_rstn,               // reset
   input wire ivr_cause_t   i_cause_en [NUM_LINES], // enables
   input wire ivr_rst_src_s i_rst_src,            // reset causes
   input wire logic         i_wdt_nmi_sel,        // nmi select
   input wire ivr_fault_s   i_fault,              // faults
   input wire logic         i_nmi_ack,            // nmi taken
   input wire logic [29:0]  o_irq_line,           // lines
   input wire logic         o_reset_req,          // reset
   input wire logic         o_nmi,                // nmi
   input wire logic         o_hard_fault,         // fault
   input wire logic [31:0]  o_vector_base_offset, // base
   input wire logic [31:0]  o_sp_vec_addr,        // sp slot
   input wire logic         o_exc_vld,            // pending
   input wire ivr_vec_s     o_exc                 // winner
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   property p_base_rst; $rose(i_rstn) |-> o_vector_base_offset == 32'h0; endproperty
   a_base_rst: assert property (p_base_rst)
      else $error("base not zero after reset");
   property p_sp_slot; o_sp_vec_addr == $past(o_vector_base_offset); endproperty
   a_sp_slot: assert property (p_sp_slot)
      else $error("sp slot off base");
   // base held steady so either register stage gives the same slot
   property p_addr;
      o_exc_vld && $stable(o_vector_base_offset)
      |-> o_exc.addr == o_vector_base_offset + {24'h0, o_exc.num, 2'b00};
   endproperty
   a_addr: assert property (p_addr)
      else $error("slot address wrong");
   property p_line_off; i_cause_en[0] == '0 |=> !o_irq_line[0]; endproperty
   a_line_off: assert property (p_line_off)
      else $error("disabled line requests");
   property p_rst_req;
      (|(i_rst_src & 5'b11101)) || (i_rst_src.wdt_overflow && !i_wdt_nmi_sel) |=> o_reset_req;
   endproperty
   a_rst_req: assert property (p_rst_req)
      else $error("reset cause lost");
   property p_nmi_set; i_rst_src.wdt_overflow && i_wdt_nmi_sel |=> o_nmi; endproperty
   a_nmi_set: assert property (p_nmi_set)
      else $error("watchdog nmi lost");
   property p_fault; |i_fault |=> o_hard_fault; endproperty
   a_fault: assert property (p_fault)
      else $error("fault lost");
   property p_nmi_hold; o_nmi && !i_nmi_ack |=> o_nmi; endproperty
   a_nmi_hold: assert property (p_nmi_hold)
      else $error("nmi dropped unacked");
   property p_nmi_win; o_nmi && !o_reset_req |=> o_exc_vld && o_exc.num == EXC_NMI; endproperty
   a_nmi_win: assert property (p_nmi_win)
      else $error("nmi outranked");
   property p_rst_win; o_reset_req |=> o_exc_vld && o_exc.num == EXC_RESET; endproperty
   a_rst_win: assert property (p_rst_win)
      else $error("reset outranked");
   property p_resv; o_exc_vld |-> o_exc.num <= EXC_IRQ_LAST && o_exc.num != 6'h0; endproperty
   a_resv: assert property (p_resv)
      else $error("reserved number pending");
endmodule

bind ivr_top ivr_chk ivr_chk_inst (.i_clk, .i_rstn, .i_cause_en, .i_rst_src, .i_wdt_nmi_sel,
   .i_fault, .i_nmi_ack, .o_irq_line, .o_reset_req, .o_nmi, .o_hard_fault,
   .o_vector_base_offset, .o_sp_vec_addr, .o_exc_vld, .o_exc);

// [tb/ivr_core_model.sv]
// interrupt request vectoring: core model taking nmi and hard fault
// watches the winner; i_lat must be 1 or more so a stale winner is not re-taken
`timescale 1ns/100ps
module ivr_core_model
   import ivr_pkg::*;
(
   input  wire logic        i_clk,       // clock
   input  wire logic        i_mask,      // holds off hard fault
   input  wire logic [3:0]  i_lat,       // cycles to take
   input  wire logic        i_exc_vld,   // pending
   input  wire ivr_vec_s    i_exc,       // winner
   output      logic        o_nmi_ack,   // nmi taken
   output      logic        o_hf_ack,    // fault taken
   output      logic        o_vbo_wr,    // base write
   output      logic [31:0] o_vbo_wdata  // base data
);
   logic [3:0] cnt = 4'h0;
   initial
   begin
      o_nmi_ack = 1'b0;
      o_hf_ack = 1'b0;
      o_vbo_wr = 1'b0;
      o_vbo_wdata = 32'h0;
   end
   // the mask never stops the nmi
   always @(negedge i_clk)
   begin
      o_nmi_ack = 1'b0;
      o_hf_ack = 1'b0;
      if (i_exc_vld && (i_exc.num == EXC_NMI || (i_exc.num == EXC_HARD_FAULT && !i_mask)))
      begin
         if (cnt == i_lat)
         begin
            o_nmi_ack = i_exc.num == EXC_NMI;
            o_hf_ack = i_exc.num == EXC_HARD_FAULT;
            cnt = 4'h0;
         end
         else
            cnt = cnt + 4'h1;
      end
      else
         cnt = 4'h0;
   end
   // a moved table still relies on the reset vector left at zero
   task automatic wr_vbo(input logic [31:0] v);
      @(negedge i_clk);
      o_vbo_wr = 1'b1;
      o_vbo_wdata = v;
      @(negedge i_clk);
      o_vbo_wr = 1'b0;
      o_vbo_wdata = ~v;
   endtask
endmodule

// [tb/ivr_top_tb.sv]
// interrupt request vectoring: self-checking bench for ivr_top
// inputs change at the falling edge; the core model acks nmi and hard fault
`timescale 1ns/100ps
module ivr_top_tb;
   import ivr_pkg::*;
   logic         clk = 1'b0;
   logic         rstn;
   ivr_cause_t   set_a [NUM_LINES];
   ivr_cause_t   clr_a [NUM_LINES];
   ivr_cause_t   en_a [NUM_LINES];
   logic [7:0]   prio_a [NUM_LINES];
   ivr_rst_src_s rst_src;
   ivr_fault_s   fault;
   logic         wsel, mask, rreq, nmi, hf, evld, nmi_ack, hf_ack, vwr;
   logic [2:0]   sys_pend;
   logic [7:0]   sys_prio [3];
   logic [29:0]  irq;
   logic [31:0]  base, sp, vdat, base_exp;
   ivr_vec_s     exc;
   int           err_total, compares;

   ivr_top ivr_top_inst (.i_clk(clk), .i_rstn(rstn), .i_cause_set(set_a), .i_cause_clr(clr_a),
      .i_cause_en(en_a), .i_line_prio(prio_a), .i_rst_src(rst_src), .i_wdt_nmi_sel(wsel),
      .i_fault(fault), .i_svc_pend(sys_pend[2]), .i_pendable_service_exception_pend(sys_pend[1]),
      .i_system_tick_exception_pend(sys_pend[0]), .i_svc_prio(sys_prio[2]), .i_pendable_service_exception_prio(sys_prio[1]),
      .i_system_tick_exception_prio(sys_prio[0]), .i_nmi_ack(nmi_ack), .i_hard_fault_ack(hf_ack),
      .i_vbo_wr(vwr),
      .i_vbo_wdata(vdat), .o_irq_line(irq), .o_reset_req(rreq), .o_nmi(nmi),
      .o_hard_fault(hf), .o_vector_base_offset(base), .o_sp_vec_addr(sp),
      .o_exc_vld(evld), .o_exc(exc));
   ivr_core_model ivr_core_model_inst (.i_clk(clk), .i_mask(mask), .i_lat(4'h3),
      .i_exc_vld(evld), .i_exc(exc), .o_nmi_ack(nmi_ack), .o_hf_ack(hf_ack),
      .o_vbo_wr(vwr), .o_vbo_wdata(vdat));

   always #12.5 clk = ~clk;

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_exc(input logic [5:0] n);
      chk("exc_vld", 32'h1, {31'h0, evld});
      chk("exc_num", {26'h0, n}, {26'h0, exc.num});
      chk("exc_addr", base_exp + {24'h0, n, 2'b00}, exc.addr);
   endtask
   task automatic pulse(input int l, input int k, input logic clr);
      if (clr)
         clr_a[l][k] = 1'b1;
      else
         set_a[l][k] = 1'b1;
      cyc(1);
      clr_a[l][k] = 1'b0;
      set_a[l][k] = 1'b0;
   endtask
   task automatic wait_taken(input logic [1:0] m);
      for (int i = 0; i < 12 && ({nmi, hf} & m) != 2'b00; i++)
         cyc(1);
      chk("taken", 32'h0, {30'h0, {nmi, hf} & m});
   endtask

   task automatic t_irq;
      int ln [4] = '{19, 19, 27, 27};
      int sl [4] = '{0, 7, 0, 4};
      en_a[0] = 16'h0002;
      pulse(0, 1, 1'b0);
      cyc(1);
      chk("line", 32'h1, {31'h0, irq[0]});
      cyc(1);
      chk_exc(EXC_IRQ_BASE);
      pulse(0, 1, 1'b1);
      cyc(1);
      chk("line", 32'h0, {31'h0, irq[0]});
      en_a[0] = 16'h0000;
      pulse(0, 0, 1'b0);
      cyc(2);
      chk("line", 32'h0, {31'h0, irq[0]});
      en_a[0] = 16'h0001;
      cyc(1);
      chk("line", 32'h1, {31'h0, irq[0]});
      en_a[0] = 16'h0000;
      en_a[1] = 16'hffff;
      pulse(1, 1, 1'b0);
      cyc(2);
      chk("line", 32'h0, {31'h0, irq[1]});
      en_a[19] = 16'hffff;
      en_a[27] = 16'hffff;
      foreach (ln[i])
      begin
         pulse(ln[i], sl[i], 1'b0);
         cyc(1);
         chk("shared", 32'h1, {31'h0, irq[ln[i]]});
         cyc(1);
         chk_exc(6'(ln[i] + 16));
         pulse(ln[i], sl[i], 1'b1);
         cyc(1);
         chk("shared", 32'h0, {31'h0, irq[ln[i]]});
      end
      $display("t_irq done");
   endtask

   task automatic t_prio;
      logic [5:0] sn [3] = '{EXC_SVC, EXC_PENDABLE_SERVICE_EXCEPTION, EXC_SYSTEM_TICK_EXCEPTION};
      en_a[3] = 16'h0001;
      en_a[5] = 16'h0001;
      prio_a[3] = 8'h40;
      prio_a[5] = 8'h80;
      set_a[3][0] = 1'b1;
      set_a[5][0] = 1'b1;
      cyc(1);
      set_a[3][0] = 1'b0;
      set_a[5][0] = 1'b0;
      cyc(2);
      chk_exc(6'h13);
      prio_a[3] = 8'hff;
      cyc(3);
      chk_exc(6'h15);
      prio_a[5] = 8'hc0;
      cyc(3);
      chk_exc(6'h13);
      // a system exception set to the bottom level must lose to a line above it
      sys_prio[2] = 8'hc0;
      prio_a[3] = 8'h40;
      sys_pend = 3'b100;
      cyc(2);
      chk_exc(6'h13);
      sys_prio[2] = 8'h00;
      cyc(2);
      chk_exc(EXC_SVC);
      en_a[3] = 16'h0000;
      en_a[5] = 16'h0000;
      for (int i = 0; i < 3; i++)
      begin
         sys_pend = 3'b100 >> i;
         cyc(2);
         chk_exc(sn[i]);
      end
      sys_pend = 3'b000;
      $display("t_prio done");
   endtask

   task automatic t_fix;
      for (int i = 0; i < 5; i++)
      begin
         rst_src = ivr_rst_src_s'(5'h01 << i);
         cyc(1);
         chk("reset_req", 32'h1, {31'h0, rreq});
         cyc(1);
         chk_exc(EXC_RESET);
      end
      rst_src = '0;
      cyc(1);
      chk("reset_req", 32'h0, {31'h0, rreq});
      mask = 1'b1;
      wsel = 1'b1;
      rst_src.wdt_overflow = 1'b1;
      fault.bus_error = 1'b1;
      cyc(1);
      rst_src = '0;
      fault = '0;
      chk("nmi_rst", 32'h2, {30'h0, nmi, rreq});
      cyc(1);
      chk_exc(EXC_NMI);
      wait_taken(2'b10);
      cyc(1);
      chk_exc(EXC_HARD_FAULT);
      mask = 1'b0;
      wait_taken(2'b01);
      for (int i = 0; i < 3; i++)
      begin
         fault = ivr_fault_s'(3'h1 << i);
         cyc(1);
         fault = '0;
         chk("fault", 32'h1, {31'h0, hf});
         cyc(1);
         chk_exc(EXC_HARD_FAULT);
         wait_taken(2'b01);
      end
      wsel = 1'b0;
      cyc(2);
      chk("idle", 32'h0, {31'h0, evld});
      $display("t_fix done");
   endtask

   task automatic t_base;
      ivr_core_model_inst.wr_vbo(32'h0000_2000);
      base_exp = 32'h0000_2000;
      cyc(2);
      chk("base", base_exp, base);
      chk("sp_slot", base_exp, sp);
      sys_pend = 3'b001;
      cyc(2);
      chk_exc(EXC_SYSTEM_TICK_EXCEPTION);
      sys_pend = 3'b000;
      rstn = 1'b0;
      cyc(2);
      rstn = 1'b1;
      base_exp = 32'h0;
      cyc(1);
      chk("base", 32'h0, base);
      $display("t_base done");
   endtask

   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      err_total = 0;
      compares = 0;
      rstn = 1'b0;
      foreach (set_a[i])
      begin
         set_a[i] = '0;
         clr_a[i] = '0;
         en_a[i] = '0;
         prio_a[i] = 8'h00;
      end
      rst_src = '0;
      fault = '0;
      wsel = 1'b0;
      mask = 1'b0;
      sys_pend = 3'b000;
      base_exp = 32'h0;
      sys_prio = '{8'h00, 8'h00, 8'h00};
      cyc(8);
      rstn = 1'b1;
      cyc(1);
      chk("base", 32'h0, base);
      chk("sp_slot", 32'h0, sp);
      chk("idle", 32'h0, {2'h0, irq});
      $display("t_reset done");
      t_irq;
      t_prio;
      t_fix;
      t_base;
      final_report;
   end

   // far beyond the hundred or so cycles the tests need
   initial
   begin
      repeat (5000) @(posedge clk);
      err_total++;
      final_report;
   end
endmodule
